// >>> rtl/mrs_pkg.sv
package mrs_pkg;

    // ------------------------------------------------------------
    // apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam int APB_AW = 8;
    localparam logic [7:0] ADDR_EXEC = 8'h00;
    localparam logic [7:0] ADDR_ACCUM = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_OPTION = 8'h0C;
    localparam logic [7:0] ADDR_PC = 8'h10;
    localparam logic [7:0] ADDR_STACK_TOP = 8'h14;
    localparam logic [7:0] ADDR_FILE_ADDR = 8'h18;
    localparam logic [7:0] ADDR_FILE_DATA = 8'h1C;
    localparam logic [7:0] ADDR_WDOG = 8'h20;

    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int OP_LSB = 0;
    localparam int OP_W = 3;
    localparam int FADDR_LSB = 8;
    localparam int FADDR_W = 5;
    localparam int DEST_BIT = 13;
    localparam int LIT_LSB = 16;
    localparam int DATA_W = 8;
    localparam int PC_W = 9;

    // ------------------------------------------------------------
    // status register bit positions
    // ------------------------------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_ZERO = 1;
    localparam int ST_SLEEP_ENTERED_N = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_PIN_WAKE = 4;
    localparam int ST_BUSY = 5;
    localparam int ST_ASLEEP = 6;

    // ------------------------------------------------------------
    // reset values and watchdog widths
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ACCUM = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [8:0] RST_PC = 9'h000;
    localparam logic [8:0] RST_STACK_TOP = 9'h000;
    localparam logic [4:0] RST_FILE_ADDR = 5'h00;
    localparam logic RST_TIMEOUT = 1'b1;
    localparam logic RST_SLEEP_ENTERED_N = 1'b1;
    localparam int WDOG_PRESC_W = 8;
    localparam int WDOG_CNT_W = 8;

    typedef enum logic [2:0] {
        MRS_OP_NOP,
        MRS_OP_STORE_ACCUM_TO_FILE,
        MRS_OP_COPY_FILE_TO_DEST,
        MRS_OP_LOAD_LITERAL_ACCUM,
        MRS_OP_OPTION_LOAD,
        MRS_OP_RETURN_WITH_LITERAL,
        MRS_OP_SLEEP,
        MRS_OP_ROTATE_LEFT_CARRY
    } mrs_op_t;

    typedef enum logic [1:0] {
        MRS_ST_IDLE,
        MRS_ST_RET2,
        MRS_ST_SLEEP
    } mrs_state_t;

endpackage

// >>> rtl/mrs_regfile.sv
`timescale 1ns/1ps
`default_nettype none

module mrs_regfile #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic ce,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // data is not reset: file contents are undefined after power-up
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // combinational read so an instruction sees its operand in the issue cycle
    assign rdata = mem[raddr];

endmodule // mrs_regfile

`default_nettype wire

// >>> rtl/mrs_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module mrs_watchdog #(
    parameter int PRESC_W = 8,
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic clear,
    output logic [CNT_W-1:0] count,
    output logic overflow
);

    // ------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------
    logic [PRESC_W-1:0] presc_reg;
    logic [PRESC_W-1:0] presc_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic ovf_reg;
    logic ovf_next;

    always_comb begin
        presc_next = presc_reg + 1'b1;
        count_next = count_reg;
        ovf_next = 1'b0;
        if (clear) begin
            presc_next = '0;
            count_next = '0;
        end else if (&presc_reg) begin
            count_next = count_reg + 1'b1;
            ovf_next = &count_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= '0;
            count_reg <= '0;
            ovf_reg <= 1'b0;
        end else if (ce) begin
            presc_reg <= presc_next;
            count_reg <= count_next;
            ovf_reg <= ovf_next;
        end
    end

    assign count = count_reg;
    assign overflow = ovf_reg;

endmodule // mrs_watchdog

`default_nettype wire

// >>> rtl/mrs_exec.sv
// Function
// RQ1 - store: accumulator copied to file register 0..31, flags untouched
// RQ2 - copy: file value goes to accumulator if dest 0, back to file if 1
// RQ3 - copy: zero flag follows the moved value, usable as zero test
// RQ4 - load literal: 8-bit immediate into accumulator, flags untouched
// RQ5 - option load: accumulator into timer configuration register, flags untouched
// RQ6 - return: literal into accumulator, program counter reloaded from stack top
// RQ7 - return takes two cycles and changes no status flag
// RQ8 - sleep clears the watchdog counter and its prescaler
// RQ9 - sleep sets timeout flag, clears sleep_entered_n, keeps pin wake flag
// RQ10 - after sleep updates, core halts oscillator and sleeps
// RQ11 - rotate left through carry, only carry changes among flags
// RQ12 - rotate result to accumulator if dest 0, to file if 1
// RQ13 - copy sets zero flag when moved value is zero, else clears it
`timescale 1ns/1ps
`default_nettype none

module mrs_exec #(
    parameter int FILE_DEPTH = 32,
    parameter int WDOG_PRESC = mrs_pkg::WDOG_PRESC_W,
    parameter int WDOG_CNT = mrs_pkg::WDOG_CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mrs_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic wake_pin,
    output logic osc_halt,
    output logic [7:0] option_value,
    output logic [8:0] pc_value
);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    mrs_pkg::mrs_state_t state_reg, state_next;
    logic exec_hit, mapped, stall, bus_fire, exec_fire;
    logic [2:0] op_bits;
    mrs_pkg::mrs_op_t op;
    logic [4:0] fa;
    logic dest;
    logic [7:0] lit;

    assign exec_hit = (paddr == mrs_pkg::ADDR_EXEC);
    assign mapped = exec_hit || (paddr == mrs_pkg::ADDR_ACCUM) ||
        (paddr == mrs_pkg::ADDR_STATUS) || (paddr == mrs_pkg::ADDR_OPTION) ||
        (paddr == mrs_pkg::ADDR_PC) || (paddr == mrs_pkg::ADDR_STACK_TOP) ||
        (paddr == mrs_pkg::ADDR_FILE_ADDR) || (paddr == mrs_pkg::ADDR_FILE_DATA) ||
        (paddr == mrs_pkg::ADDR_WDOG);
    // a new instruction waits out the second cycle of a return
    assign stall = exec_hit && pwrite && (state_reg == mrs_pkg::MRS_ST_RET2);
    assign pready = ce && psel && penable && !stall;
    // instructions are refused while asleep: the oscillator is meant to be off
    assign pslverr = pready && (!mapped ||
        (exec_hit && pwrite && state_reg == mrs_pkg::MRS_ST_SLEEP));
    assign bus_fire = pready && pwrite && !pslverr;
    assign exec_fire = bus_fire && exec_hit;

    assign op_bits = pwdata[mrs_pkg::OP_LSB +: mrs_pkg::OP_W];
    assign op = mrs_pkg::mrs_op_t'(op_bits);
    assign fa = pwdata[mrs_pkg::FADDR_LSB +: mrs_pkg::FADDR_W];
    assign dest = pwdata[mrs_pkg::DEST_BIT];
    assign lit = pwdata[mrs_pkg::LIT_LSB +: mrs_pkg::DATA_W];

    // ------------------------------------------------------------
    // core state
    // ------------------------------------------------------------
    logic [7:0] accum_reg, accum_next, option_reg, option_next;
    logic [8:0] pc_reg, pc_next, stack_top_reg, stack_top_next;
    logic [4:0] file_addr_reg, file_addr_next;
    logic [31:0] instr_reg, instr_next, prdata_reg, prdata_next;
    logic carry_reg, carry_next, zero_reg, zero_next;
    logic timeout_flag_reg, timeout_flag_next;
    logic sleep_entered_n_reg, sleep_entered_n_next;
    logic pin_wake_flag_reg, pin_wake_flag_next;
    logic rf_we, wdog_clear, wdog_ovf;
    logic [4:0] rf_waddr, rf_raddr;
    logic [7:0] rf_wdata, rf_rdata, rot;
    logic [WDOG_CNT-1:0] wdog_count;
    logic [31:0] status_word;

    assign rf_raddr = exec_hit ? fa : file_addr_reg;
    assign rot = {rf_rdata[6:0], carry_reg};

    always_comb begin
        state_next = state_reg;
        accum_next = accum_reg;
        option_next = option_reg;
        pc_next = pc_reg;
        stack_top_next = stack_top_reg;
        file_addr_next = file_addr_reg;
        instr_next = instr_reg;
        carry_next = carry_reg;
        zero_next = zero_reg;
        timeout_flag_next = timeout_flag_reg;
        sleep_entered_n_next = sleep_entered_n_reg;
        pin_wake_flag_next = pin_wake_flag_reg;
        rf_we = 1'b0;
        rf_waddr = fa;
        rf_wdata = accum_reg;
        wdog_clear = 1'b0;
        // plain software writes first, so hardware updates below win
        if (bus_fire && !exec_hit) begin
            case (paddr)
                mrs_pkg::ADDR_ACCUM: accum_next = pwdata[7:0];
                mrs_pkg::ADDR_STATUS: begin
                    carry_next = pwdata[mrs_pkg::ST_CARRY];
                    zero_next = pwdata[mrs_pkg::ST_ZERO];
                    pin_wake_flag_next = pwdata[mrs_pkg::ST_PIN_WAKE];
                end
                mrs_pkg::ADDR_PC: pc_next = pwdata[8:0];
                mrs_pkg::ADDR_STACK_TOP: stack_top_next = pwdata[8:0];
                mrs_pkg::ADDR_FILE_ADDR: file_addr_next = pwdata[4:0];
                mrs_pkg::ADDR_FILE_DATA: begin
                    rf_we = 1'b1;
                    rf_waddr = file_addr_reg;
                    rf_wdata = pwdata[7:0];
                end
                default: ;
            endcase
        end
        case (state_reg)
            mrs_pkg::MRS_ST_IDLE: begin
                if (exec_fire) begin
                    instr_next = pwdata;
                    pc_next = pc_reg + 9'h001;
                    case (op)
                        mrs_pkg::MRS_OP_STORE_ACCUM_TO_FILE: begin
                            rf_we = 1'b1; // RQ1
                        end
                        mrs_pkg::MRS_OP_COPY_FILE_TO_DEST: begin
                            if (dest) begin
                                rf_we = 1'b1; // RQ2
                                rf_wdata = rf_rdata;
                            end else begin
                                accum_next = rf_rdata; // RQ2
                            end
                            zero_next = (rf_rdata == 8'h00); // RQ3 RQ13
                        end
                        mrs_pkg::MRS_OP_LOAD_LITERAL_ACCUM: accum_next = lit; // RQ4
                        mrs_pkg::MRS_OP_OPTION_LOAD: option_next = accum_reg; // RQ5
                        mrs_pkg::MRS_OP_RETURN_WITH_LITERAL: begin
                            accum_next = lit; // RQ6
                            state_next = mrs_pkg::MRS_ST_RET2; // RQ7
                        end
                        mrs_pkg::MRS_OP_SLEEP: begin
                            wdog_clear = 1'b1; // RQ8
                            timeout_flag_next = 1'b1; // RQ9
                            sleep_entered_n_next = 1'b0; // RQ9
                            state_next = mrs_pkg::MRS_ST_SLEEP; // RQ10
                        end
                        mrs_pkg::MRS_OP_ROTATE_LEFT_CARRY: begin
                            carry_next = rf_rdata[7]; // RQ11
                            if (dest) begin
                                rf_we = 1'b1; // RQ12
                                rf_wdata = rot;
                            end else begin
                                accum_next = rot; // RQ12
                            end
                        end
                        default: ;
                    endcase
                end
            end
            mrs_pkg::MRS_ST_RET2: begin
                pc_next = stack_top_reg; // RQ6 RQ7
                state_next = mrs_pkg::MRS_ST_IDLE;
            end
            mrs_pkg::MRS_ST_SLEEP: begin
                // a watchdog overflow while asleep is a timeout wake-up
                if (wdog_ovf) begin
                    timeout_flag_next = 1'b0;
                    state_next = mrs_pkg::MRS_ST_IDLE;
                end else if (wake_pin) begin
                    pin_wake_flag_next = 1'b1;
                    state_next = mrs_pkg::MRS_ST_IDLE;
                end
            end
            default: state_next = mrs_pkg::MRS_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= mrs_pkg::MRS_ST_IDLE;
            accum_reg <= mrs_pkg::RST_ACCUM;
            option_reg <= mrs_pkg::RST_OPTION;
            pc_reg <= mrs_pkg::RST_PC;
            stack_top_reg <= mrs_pkg::RST_STACK_TOP;
            file_addr_reg <= mrs_pkg::RST_FILE_ADDR;
            instr_reg <= 32'h00000000;
            carry_reg <= 1'b0;
            zero_reg <= 1'b0;
            timeout_flag_reg <= mrs_pkg::RST_TIMEOUT;
            sleep_entered_n_reg <= mrs_pkg::RST_SLEEP_ENTERED_N;
            pin_wake_flag_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            accum_reg <= accum_next;
            option_reg <= option_next;
            pc_reg <= pc_next;
            stack_top_reg <= stack_top_next;
            file_addr_reg <= file_addr_next;
            instr_reg <= instr_next;
            carry_reg <= carry_next;
            zero_reg <= zero_next;
            timeout_flag_reg <= timeout_flag_next;
            sleep_entered_n_reg <= sleep_entered_n_next;
            pin_wake_flag_reg <= pin_wake_flag_next;
        end
    end

    // ------------------------------------------------------------
    // read data, captured in the setup cycle so prdata is a flop
    // ------------------------------------------------------------
    always_comb begin
        status_word = 32'h00000000;
        status_word[mrs_pkg::ST_CARRY] = carry_reg;
        status_word[mrs_pkg::ST_ZERO] = zero_reg;
        status_word[mrs_pkg::ST_SLEEP_ENTERED_N] = sleep_entered_n_reg;
        status_word[mrs_pkg::ST_TIMEOUT] = timeout_flag_reg;
        status_word[mrs_pkg::ST_PIN_WAKE] = pin_wake_flag_reg;
        status_word[mrs_pkg::ST_BUSY] = (state_reg == mrs_pkg::MRS_ST_RET2);
        status_word[mrs_pkg::ST_ASLEEP] = (state_reg == mrs_pkg::MRS_ST_SLEEP);
        prdata_next = prdata_reg;
        if (psel && !penable) begin
            case (paddr)
                mrs_pkg::ADDR_EXEC: prdata_next = instr_reg;
                mrs_pkg::ADDR_ACCUM: prdata_next = {24'h000000, accum_reg};
                mrs_pkg::ADDR_STATUS: prdata_next = status_word;
                mrs_pkg::ADDR_OPTION: prdata_next = {24'h000000, option_reg};
                mrs_pkg::ADDR_PC: prdata_next = {23'h000000, pc_reg};
                mrs_pkg::ADDR_STACK_TOP: prdata_next = {23'h000000, stack_top_reg};
                mrs_pkg::ADDR_FILE_ADDR: prdata_next = {27'h0000000, file_addr_reg};
                mrs_pkg::ADDR_FILE_DATA: prdata_next = {24'h000000, rf_rdata};
                mrs_pkg::ADDR_WDOG: prdata_next = 32'(wdog_count);
                default: prdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (ce) begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;
    assign osc_halt = (state_reg == mrs_pkg::MRS_ST_SLEEP);
    assign option_value = option_reg;
    assign pc_value = pc_reg;

    // ------------------------------------------------------------
    // file registers and watchdog
    // ------------------------------------------------------------
    mrs_regfile #(.DEPTH(FILE_DEPTH), .WIDTH(mrs_pkg::DATA_W)) u_regfile (
        .pclk(pclk),
        .ce(ce),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata),
        .raddr(rf_raddr),
        .rdata(rf_rdata)
    );

    mrs_watchdog #(.PRESC_W(WDOG_PRESC), .CNT_W(WDOG_CNT)) u_watchdog (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .clear(wdog_clear && ce),
        .count(wdog_count),
        .overflow(wdog_ovf)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    sequence s_issue_ret;
        exec_fire && state_reg == mrs_pkg::MRS_ST_IDLE
        && op == mrs_pkg::MRS_OP_RETURN_WITH_LITERAL;
    endsequence
    sequence s_ret_done;
        state_reg == mrs_pkg::MRS_ST_RET2 ##1 state_reg == mrs_pkg::MRS_ST_IDLE;
    endsequence

    a_store_no_flags: assert property ( // RQ1
        exec_fire && state_reg == mrs_pkg::MRS_ST_IDLE
        && op == mrs_pkg::MRS_OP_STORE_ACCUM_TO_FILE
        |=> $stable(carry_reg) && $stable(zero_reg) && $stable(accum_reg))
        else $error("store changed a flag or the accumulator");
    a_copy_to_accum: assert property ( // RQ2
        exec_fire && state_reg == mrs_pkg::MRS_ST_IDLE && op == mrs_pkg::MRS_OP_COPY_FILE_TO_DEST
        && !dest |=> accum_reg == $past(rf_rdata))
        else $error("copy did not reach the accumulator");
    a_copy_zero_flag: assert property ( // RQ3
        exec_fire && state_reg == mrs_pkg::MRS_ST_IDLE && op == mrs_pkg::MRS_OP_COPY_FILE_TO_DEST
        |=> zero_reg == ($past(rf_rdata) == 8'h00) && $stable(carry_reg))
        else $error("copy zero flag wrong");
    a_literal_load: assert property ( // RQ4
        exec_fire && state_reg == mrs_pkg::MRS_ST_IDLE && op == mrs_pkg::MRS_OP_LOAD_LITERAL_ACCUM
        |=> accum_reg == $past(lit) && $stable(zero_reg) && $stable(carry_reg))
        else $error("literal load wrong");
    a_option_load: assert property ( // RQ5
        exec_fire && state_reg == mrs_pkg::MRS_ST_IDLE && op == mrs_pkg::MRS_OP_OPTION_LOAD
        |=> option_value == $past(accum_reg) && $stable(zero_reg))
        else $error("option load wrong");
    a_return_two_cycle: assert property ( // RQ7
        s_issue_ret |=> s_ret_done)
        else $error("return did not take two cycles");
    a_return_pc_load: assert property ( // RQ6
        s_issue_ret ##1 state_reg == mrs_pkg::MRS_ST_RET2
        |=> pc_value == $past(stack_top_reg) && accum_reg == $past(lit, 2))
        else $error("return did not reload pc and accumulator");
    a_sleep_entry: assert property ( // RQ9
        exec_fire && state_reg == mrs_pkg::MRS_ST_IDLE && op == mrs_pkg::MRS_OP_SLEEP
        |=> timeout_flag_reg && !sleep_entered_n_reg && $stable(pin_wake_flag_reg)
            && wdog_count == '0)
        else $error("sleep flags or watchdog wrong"); // RQ8
    a_sleep_halts: assert property ( // RQ10
        exec_fire && state_reg == mrs_pkg::MRS_ST_IDLE && op == mrs_pkg::MRS_OP_SLEEP
        |=> osc_halt)
        else $error("oscillator not halted after sleep");
    a_rotate_left: assert property ( // RQ11
        exec_fire && state_reg == mrs_pkg::MRS_ST_IDLE && op == mrs_pkg::MRS_OP_ROTATE_LEFT_CARRY
        && !dest |=> accum_reg == {$past(rf_rdata[6:0]), $past(carry_reg)}
            && carry_reg == $past(rf_rdata[7]) && $stable(zero_reg))
        else $error("rotate left wrong"); // RQ12

endmodule // mrs_exec

`default_nettype wire

// >>> tb/move_return_sleep_rotate_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module move_return_sleep_rotate_exec_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic wake_pin = 1'b0;
    logic pready, pslverr, osc_halt, errv;
    logic [31:0] prdata, rdv, st0;
    logic [7:0] option_value;
    logic [8:0] pc_value;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #20 pclk = ~pclk;
    mrs_exec dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .wake_pin(wake_pin), .osc_halt(osc_halt),
        .option_value(option_value), .pc_value(pc_value));
    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // a hang in a wait loop ends up here instead of running forever
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // apb master
    // ------------------------------------------------------------
    // ready and data are read right at the rising edge, before the design's flops update
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic ex(input logic [2:0] op, input logic [4:0] f, input logic d,
                      input logic [7:0] k);
        apb(1'b1, mrs_pkg::ADDR_EXEC, {8'h00, k, 2'b00, d, f, 5'h00, op});
    endtask
    task automatic file_set(input logic [4:0] f, input logic [7:0] v);
        apb(1'b1, mrs_pkg::ADDR_FILE_ADDR, {27'h0, f});
        apb(1'b1, mrs_pkg::ADDR_FILE_DATA, {24'h0, v});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(mrs_pkg::ADDR_ACCUM);
        chk("accum reset", 32'h0, rdv);
        chk("option reset", 32'hFF, {24'h0, option_value});
        rd(mrs_pkg::ADDR_STATUS);
        chk("status reset", 32'h0C, rdv & 32'h1F);
        rd(8'h40);
        chk("unmapped err", 32'h1, {31'h0, errv});
    endtask
    task automatic t_load_store;
        apb(1'b1, mrs_pkg::ADDR_STATUS, 32'h3);
        rd(mrs_pkg::ADDR_STATUS);
        st0 = rdv;
        ex(mrs_pkg::MRS_OP_LOAD_LITERAL_ACCUM, 5'h00, 1'b0, 8'hFF);
        rd(mrs_pkg::ADDR_ACCUM);
        chk("literal ff", 32'hFF, rdv);
        ex(mrs_pkg::MRS_OP_LOAD_LITERAL_ACCUM, 5'h00, 1'b0, 8'h5A);
        ex(mrs_pkg::MRS_OP_STORE_ACCUM_TO_FILE, 5'h1F, 1'b0, 8'h00);
        apb(1'b1, mrs_pkg::ADDR_FILE_ADDR, 32'h1F);
        rd(mrs_pkg::ADDR_FILE_DATA);
        chk("store f31", 32'h5A, rdv);
        rd(mrs_pkg::ADDR_STATUS);
        chk("flags kept", st0, rdv);
    endtask
    task automatic t_copy;
        file_set(5'h03, 8'h00);
        ex(mrs_pkg::MRS_OP_LOAD_LITERAL_ACCUM, 5'h00, 1'b0, 8'h77);
        ex(mrs_pkg::MRS_OP_COPY_FILE_TO_DEST, 5'h03, 1'b0, 8'h00);
        rd(mrs_pkg::ADDR_ACCUM);
        chk("copy to accum", 32'h0, rdv);
        rd(mrs_pkg::ADDR_STATUS);
        chk("zero set", 32'h1, {31'h0, rdv[mrs_pkg::ST_ZERO]});
        file_set(5'h03, 8'h40);
        ex(mrs_pkg::MRS_OP_COPY_FILE_TO_DEST, 5'h03, 1'b1, 8'h00);
        rd(mrs_pkg::ADDR_FILE_DATA);
        chk("copy to file", 32'h40, rdv);
        rd(mrs_pkg::ADDR_ACCUM);
        chk("accum kept", 32'h0, rdv);
        rd(mrs_pkg::ADDR_STATUS);
        chk("zero clear", 32'h0, {31'h0, rdv[mrs_pkg::ST_ZERO]});
    endtask
    task automatic t_option_ret;
        ex(mrs_pkg::MRS_OP_LOAD_LITERAL_ACCUM, 5'h00, 1'b0, 8'h3C);
        ex(mrs_pkg::MRS_OP_OPTION_LOAD, 5'h00, 1'b0, 8'h00);
        @(posedge pclk);
        chk("option load", 32'h3C, {24'h0, option_value});
        apb(1'b1, mrs_pkg::ADDR_STATUS, 32'h3);
        apb(1'b1, mrs_pkg::ADDR_STACK_TOP, 32'h1AB);
        ex(mrs_pkg::MRS_OP_RETURN_WITH_LITERAL, 5'h00, 1'b0, 8'h99);
        // the next issue comes as soon as the bus allows, after the return's second cycle
        ex(mrs_pkg::MRS_OP_NOP, 5'h00, 1'b0, 8'h00);
        chk("nop after ret", 32'h0, {31'h0, errv});
        rd(mrs_pkg::ADDR_ACCUM);
        chk("ret literal", 32'h99, rdv);
        chk("ret pc", 32'h1AC, {23'h0, pc_value});
        rd(mrs_pkg::ADDR_STATUS);
        chk("ret flags", 32'h3, rdv & 32'h3);
    endtask
    task automatic t_rotate;
        apb(1'b1, mrs_pkg::ADDR_STATUS, 32'h2);
        file_set(5'h07, 8'h81);
        ex(mrs_pkg::MRS_OP_ROTATE_LEFT_CARRY, 5'h07, 1'b0, 8'h00);
        rd(mrs_pkg::ADDR_ACCUM);
        chk("rot accum", 32'h02, rdv);
        rd(mrs_pkg::ADDR_STATUS);
        chk("rot carry", 32'h3, rdv & 32'h3);
        ex(mrs_pkg::MRS_OP_ROTATE_LEFT_CARRY, 5'h07, 1'b1, 8'h00);
        rd(mrs_pkg::ADDR_FILE_DATA);
        chk("rot file", 32'h03, rdv);
    endtask
    task automatic t_sleep;
        // let the watchdog advance first so the clear is visible
        repeat (600) @(posedge pclk);
        ex(mrs_pkg::MRS_OP_SLEEP, 5'h00, 1'b0, 8'h00);
        @(posedge pclk);
        chk("halted", 32'h1, {31'h0, osc_halt});
        rd(mrs_pkg::ADDR_WDOG);
        chk("wdog clear", 32'h0, rdv);
        rd(mrs_pkg::ADDR_STATUS);
        chk("sleep flags", 32'h48, rdv & 32'h5C);
        ex(mrs_pkg::MRS_OP_NOP, 5'h00, 1'b0, 8'h00);
        chk("exec asleep", 32'h1, {31'h0, errv});
        @(posedge pclk);
        wake_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        wake_pin <= 1'b0;
        chk("woken", 32'h0, {31'h0, osc_halt});
        rd(mrs_pkg::ADDR_STATUS);
        chk("wake flags", 32'h18, rdv & 32'h5C);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_load_store();
        t_copy();
        t_option_ret();
        t_rotate();
        t_sleep();
        print_verdict();
    end
endmodule // move_return_sleep_rotate_exec_tb_top
`default_nettype wire
